// file: rtl/bss_pkg.sv
// Constants and carrier types for the backup supply switchover block.
// Assumes comparator results arrive as asynchronous digital levels.
package bss_pkg;

  // Synchroniser depth for comparator inputs
  localparam int SYNC_STAGES = 3;

  // Reset values
  localparam logic LP_MODE_RST = 1'b0;
  localparam logic TPL_FLAG_RST = 1'b1;

  // Supply comparator results, one bit per comparison
  typedef struct packed {
    logic main_present;     // Main supply above minimum to run at all
    logic backup_present;   // Backup supply above zero (any charge)
    logic below_bak_hys;    // Main below backup minus backup hysteresis
    logic above_bak_hys;    // Main above backup plus backup hysteresis
    logic below_trip;       // Main below trip threshold
    logic above_trip_hys;   // Main above trip plus trip hysteresis
    logic below_bak;        // Main below backup, no hysteresis
    logic bak_above_min;    // Backup supply at or above storage minimum
  } bss_cmp_t;

  localparam int CMP_W = $bits(bss_cmp_t);

  // Domain enables granted by the power controller
  typedef struct packed {
    logic serial_en;        // Serial clock/data buffers enabled
    logic storage_en;       // User storage enabled
    logic timekeep_en;      // Clock and calendar counting enabled
    logic backup_draw;      // Backup source connected
  } bss_en_t;

endpackage

// file: rtl/bss_core.sv
// Power control for a battery backed clock: supply mode, gating, flag.
// Assumes comparator results are raw levels from analog comparators.
`timescale 1ns/1ps
`default_nettype none
module bss_core (
  input wire logic clk,
  input wire logic rstn,
  input wire bss_pkg::bss_cmp_t cmp_raw,
  input wire logic low_power_switch_mode_wr,
  input wire logic low_power_switch_mode_in,
  input wire logic total_power_loss_flag_clr,
  input wire logic backup_irq_en,
  input wire logic backup_fout_en,
  input wire logic alarm_event_n,
  input wire logic fout_clk,
  input wire logic fout_sel_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_drive_low,
  output logic backup_mode,
  output logic low_power_switch_mode,
  output logic total_power_loss_flag,
  output logic trip_monitor_en,
  output var bss_pkg::bss_en_t enables,
  output logic scl_int,
  output logic sda_int,
  output logic sda_o,
  output logic sda_oe,
  output logic irq_o,
  output logic irq_oe,
  output logic fout_o,
  output logic fout_oe
);

  typedef enum logic [1:0] {BSS_UNPOWERED, BSS_NORMAL, BSS_BACKUP} bss_state_t;

  // ********************************************
  // Shared decodes
  // ********************************************
  // Both supplies gone, nothing left to run from
  function automatic logic supplies_lost(input bss_pkg::bss_cmp_t c);
    return !c.backup_present && !c.main_present;
  endfunction

  // A pin may stay active in backup only if its keep bit is set
  function automatic logic pin_kept(input logic in_backup, input logic keep);
    return !in_backup || keep;
  endfunction

  // ********************************************
  // Input synchronisers
  // ********************************************
  logic [bss_pkg::CMP_W-1:0] s1_q, s2_q, s3_q;
  bss_pkg::bss_cmp_t cmp_q;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= cmp_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered comparator results per bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_q <= '0;
    end else begin
      for (int i = 0; i < bss_pkg::CMP_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          cmp_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ********************************************
  // Low power switching configuration
  // ********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_power_switch_mode <= bss_pkg::LP_MODE_RST;
    end else if (low_power_switch_mode_wr && !backup_mode) begin
      low_power_switch_mode <= low_power_switch_mode_in;
    end
  end

  // Trip comparator powered down in low power switching
  assign trip_monitor_en = !low_power_switch_mode;

  // ********************************************
  // Switchover conditions
  // ********************************************
  logic enter_backup;
  logic leave_backup;

  always_comb begin
    if (low_power_switch_mode) begin
      enter_backup = cmp_q.below_bak;
      leave_backup = cmp_q.above_bak_hys;
    end else begin
      enter_backup = cmp_q.below_bak_hys && cmp_q.below_trip;
      leave_backup = cmp_q.above_bak_hys || cmp_q.above_trip_hys;
    end
  end

  // ********************************************
  // Supply mode state machine
  // ********************************************
  bss_state_t state_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= BSS_UNPOWERED;
    end else begin
      case (state_q)
        BSS_UNPOWERED: begin
          if (cmp_q.main_present) begin
            state_q <= BSS_NORMAL;
          end
        end
        BSS_NORMAL: begin
          if (enter_backup) begin
            state_q <= BSS_BACKUP;
          end
        end
        BSS_BACKUP: begin
          if (leave_backup) begin
            state_q <= BSS_NORMAL;
          end else if (supplies_lost(cmp_q)) begin
            state_q <= BSS_UNPOWERED;
          end
        end
        default: begin
          state_q <= BSS_UNPOWERED;
        end
      endcase
    end
  end

  assign backup_mode = (state_q == BSS_BACKUP);

  // ********************************************
  // Total power loss flag
  // ********************************************
  // Set on reset (power-up after total loss) and on dropping to unpowered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      total_power_loss_flag <= bss_pkg::TPL_FLAG_RST;
    end else if (state_q == BSS_BACKUP && supplies_lost(cmp_q)) begin
      total_power_loss_flag <= 1'b1;
    end else if (total_power_loss_flag_clr) begin
      total_power_loss_flag <= 1'b0;
    end
  end

  // ********************************************
  // Domain enables and serial gating
  // ********************************************
  always_comb begin
    enables.serial_en = (state_q == BSS_NORMAL);
    enables.timekeep_en = (state_q != BSS_UNPOWERED);
    enables.storage_en = (state_q == BSS_NORMAL) ||
                         (backup_mode && cmp_q.bak_above_min);
    enables.backup_draw = backup_mode;
  end

  // Serial inputs held idle high when gated
  assign scl_int = enables.serial_en ? scl_in : 1'b1;
  assign sda_int = enables.serial_en ? sda_in : 1'b1;

  // Open drain data: enable low drives low
  assign sda_o = 1'b0;
  assign sda_oe = !(enables.serial_en && sda_drive_low);

  // ********************************************
  // Open drain interrupt and frequency outputs
  // ********************************************
  logic irq_act_q;
  logic fout_act_q;

  // Pins stay active in backup unless disabled by configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_act_q <= 1'b0;
    end else begin
      irq_act_q <= !alarm_event_n && !fout_sel_en &&
                   pin_kept(backup_mode, backup_irq_en);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fout_act_q <= 1'b0;
    end else begin
      fout_act_q <= fout_sel_en && !fout_clk &&
                    pin_kept(backup_mode, backup_fout_en);
    end
  end

  assign irq_o = 1'b0;
  assign irq_oe = !irq_act_q;
  assign fout_o = 1'b0;
  assign fout_oe = !fout_act_q;

  // ********************************************
  // Checks
  // ********************************************
  a_serial_gated: assert property (@(posedge clk) disable iff (!rstn)
    backup_mode |-> (sda_oe && scl_int && sda_int))
    else $error("serial pins active in backup");

  a_enter_cond: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(backup_mode) && !$past(low_power_switch_mode)) |->
      ($past(cmp_q.below_bak_hys) && $past(cmp_q.below_trip)))
    else $error("backup entered without both conditions");

  a_leave_cond: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && !low_power_switch_mode &&
     (cmp_q.above_bak_hys || cmp_q.above_trip_hys)) |=> !backup_mode)
    else $error("backup not left on exit condition");

  a_lp_enter: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_NORMAL && low_power_switch_mode && cmp_q.below_bak)
      |=> backup_mode)
    else $error("low power switching did not enter backup");

  a_trip_off: assert property (@(posedge clk) disable iff (!rstn)
    low_power_switch_mode |-> !trip_monitor_en)
    else $error("trip monitor on in low power switching");

  a_lp_reset: assert property (@(posedge clk)
    $rose(rstn) |-> !low_power_switch_mode)
    else $error("low power bit not zero after reset");

  a_no_draw: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_UNPOWERED) |=> !backup_mode)
    else $error("backup drawn before main power");

  a_time_kept: assert property (@(posedge clk) disable iff (!rstn)
    $rose(backup_mode) |-> enables.timekeep_en [*3])
    else $error("timekeeping lost at switchover");

  a_store_kept: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && cmp_q.bak_above_min) |-> enables.storage_en)
    else $error("storage off in backup above minimum");

  a_flag_reset: assert property (@(posedge clk)
    $rose(rstn) |-> total_power_loss_flag)
    else $error("power loss flag clear after power-up");

  a_irq_od: assert property (@(posedge clk) disable iff (!rstn)
    (!alarm_event_n && !fout_sel_en && !backup_mode) |=> !irq_oe)
    else $error("interrupt not driven low on alarm");

  a_mode_stable: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_NORMAL && !enter_backup) |=> !backup_mode)
    else $error("mode changed without condition");

  a_normal_enter: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_NORMAL && !low_power_switch_mode &&
     cmp_q.below_bak_hys && cmp_q.below_trip) |=> backup_mode)
    else $error("backup not entered on both conditions");

  a_lp_leave: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && low_power_switch_mode && cmp_q.above_bak_hys) |=>
      !backup_mode)
    else $error("low power switching did not leave backup");

  a_wake_main: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_UNPOWERED && cmp_q.main_present) |=>
      (state_q == BSS_NORMAL))
    else $error("main supply did not wake the block");

  a_flag_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_BACKUP && supplies_lost(cmp_q)) |=>
      total_power_loss_flag)
    else $error("power loss flag not set on total loss");

  a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
    (total_power_loss_flag_clr &&
     !(state_q == BSS_BACKUP && supplies_lost(cmp_q))) |=>
      !total_power_loss_flag)
    else $error("power loss flag not cleared");

  a_lp_write: assert property (@(posedge clk) disable iff (!rstn)
    (low_power_switch_mode_wr && !backup_mode) |=>
      (low_power_switch_mode == $past(low_power_switch_mode_in)))
    else $error("low power bit write lost");

  a_lp_refused: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && low_power_switch_mode_wr) |=>
      $stable(low_power_switch_mode))
    else $error("low power bit written in backup");

  a_irq_masked: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && !backup_irq_en) |=> irq_oe)
    else $error("interrupt pin active in backup when masked");

  a_fout_masked: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && !backup_fout_en) |=> fout_oe)
    else $error("frequency pin active in backup when masked");

  a_fout_od: assert property (@(posedge clk) disable iff (!rstn)
    (fout_sel_en && !fout_clk && !backup_mode) |=> !fout_oe)
    else $error("frequency output not driven low");

  a_irq_idle: assert property (@(posedge clk) disable iff (!rstn)
    alarm_event_n |=> irq_oe)
    else $error("interrupt pin driven without alarm");

  a_sda_drive: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSS_NORMAL && sda_drive_low) |-> !sda_oe)
    else $error("data pin not driven in normal mode");

  a_store_low: assert property (@(posedge clk) disable iff (!rstn)
    (backup_mode && !cmp_q.bak_above_min) |-> !enables.storage_en)
    else $error("storage on in backup below minimum");

endmodule
`default_nettype wire

// file: test/bss_sup_model.sv
// Comparator model for the supply switchover block.
// Assumes the bench gives both supplies in millivolts.
`timescale 1ns/1ps
`default_nettype none
module bss_sup_model #(
  parameter int TRIP_MV = 2200,
  parameter int BAK_HYS_MV = 50,
  parameter int TRIP_HYS_MV = 30,
  parameter int STORE_MIN_MV = 2000,
  parameter int RUN_MIN_MV = 1000
) (
  input var int main_mv,
  input var int bak_mv,
  output var bss_pkg::bss_cmp_t cmp
);
  // ************************************************
  // Ideal comparators, levels follow the supplies
  // ************************************************
  always_comb begin
    cmp.main_present = main_mv > RUN_MIN_MV;
    cmp.backup_present = bak_mv > 0;
    cmp.below_bak_hys = main_mv < bak_mv - BAK_HYS_MV;
    cmp.above_bak_hys = main_mv > bak_mv + BAK_HYS_MV;
    cmp.below_trip = main_mv < TRIP_MV;
    cmp.above_trip_hys = main_mv > TRIP_MV + TRIP_HYS_MV;
    cmp.below_bak = main_mv < bak_mv;
    cmp.bak_above_min = bak_mv >= STORE_MIN_MV;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the supply switchover block.
// Assumes comparator changes reach the mode within five edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rstn, low_power_switch_mode_wr, low_power_switch_mode_in;
  logic total_power_loss_flag_clr, backup_irq_en, backup_fout_en;
  logic alarm_event_n, fout_clk, fout_sel_en, scl_in, sda_in;
  logic sda_drive_low, backup_mode, low_power_switch_mode;
  logic total_power_loss_flag, trip_monitor_en, scl_int, sda_int;
  logic sda_o, sda_oe, irq_o, irq_oe, fout_o, fout_oe;
  int main_mv, bak_mv, num_errors, compares;
  bss_pkg::bss_cmp_t cmp_raw;
  bss_pkg::bss_en_t enables;

  bss_sup_model u_sup (.main_mv, .bak_mv, .cmp(cmp_raw));
  bss_core u_dut (.clk, .rstn, .cmp_raw, .low_power_switch_mode_wr,
    .low_power_switch_mode_in, .total_power_loss_flag_clr,
    .backup_irq_en, .backup_fout_en, .alarm_event_n, .fout_clk,
    .fout_sel_en, .scl_in, .sda_in, .sda_drive_low, .backup_mode,
    .low_power_switch_mode, .total_power_loss_flag, .trip_monitor_en,
    .enables, .scl_int, .sda_int, .sda_o, .sda_oe, .irq_o, .irq_oe,
    .fout_o, .fout_oe);

  // Clock, 100 ns period
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic sup(input int m, input int b);
    @(posedge clk);
    main_mv <= m;
    bak_mv <= b;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic wr_lp(input logic v);
    @(posedge clk);
    low_power_switch_mode_wr <= 1'h1;
    low_power_switch_mode_in <= v;
    @(posedge clk);
    low_power_switch_mode_wr <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset;
    repeat (7) @(posedge clk);
    #1;
    chk(total_power_loss_flag, 1'h1, "flag reset");
    chk(low_power_switch_mode, 1'h0, "lp reset");
    chk(trip_monitor_en, 1'h1, "trip mon reset");
    @(posedge clk);
    rstn <= 1'h1;
    sup(0, 3000);
    chk(enables.backup_draw, 1'h0, "draw before main");
    chk(backup_mode, 1'h0, "mode before main");
    sup(3300, 3000);
    chk(enables.serial_en, 1'h1, "serial on");
    chk(scl_int, 1'h0, "scl passes");
    chk(sda_int, 1'h0, "sda passes");
    chk(sda_o, 1'h0, "sda level");
    chk(sda_oe, 1'h0, "sda drives");
    $display("test reset done");
  endtask

  task automatic t_enter;
    sup(2500, 3000);
    chk(backup_mode, 1'h0, "one condition only");
    sup(2000, 3000);
    chk(backup_mode, 1'h1, "both conditions");
    chk(enables.serial_en, 1'h0, "serial off");
    chk(scl_int, 1'h1, "scl gated");
    chk(sda_int, 1'h1, "sda gated");
    chk(sda_oe, 1'h1, "sda released");
    chk(enables.timekeep_en, 1'h1, "timekeeping");
    chk(enables.storage_en, 1'h1, "storage");
    chk(enables.backup_draw, 1'h1, "draw");
    chk(irq_oe, 1'h0, "irq in backup");
    @(posedge clk);
    backup_irq_en <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(irq_oe, 1'h1, "irq masked in backup");
    chk(irq_o, 1'h0, "irq level");
    @(posedge clk);
    backup_irq_en <= 1'h1;
    sup(2250, 3000);
    chk(backup_mode, 1'h0, "exit over trip");
    sup(1500, 1900);
    chk(enables.storage_en, 1'h0, "storage low");
    sup(1900, 2100);
    chk(enables.storage_en, 1'h1, "storage ok");
    chk(backup_mode, 1'h1, "still backup");
    sup(2160, 2100);
    chk(backup_mode, 1'h0, "exit over backup");
    $display("test switchover done");
  endtask

  task automatic t_lowpower;
    sup(3300, 3000);
    wr_lp(1'h1);
    chk(low_power_switch_mode, 1'h1, "lp set");
    chk(trip_monitor_en, 1'h0, "trip mon off");
    sup(2900, 3000);
    chk(backup_mode, 1'h1, "lp enter");
    wr_lp(1'h0);
    chk(low_power_switch_mode, 1'h1, "write refused");
    sup(3100, 3000);
    chk(backup_mode, 1'h0, "lp exit");
    wr_lp(1'h0);
    chk(low_power_switch_mode, 1'h0, "lp clear");
    $display("test low power done");
  endtask

  task automatic t_loss;
    @(posedge clk);
    total_power_loss_flag_clr <= 1'h1;
    @(posedge clk);
    total_power_loss_flag_clr <= 1'h0;
    @(posedge clk);
    #1;
    chk(total_power_loss_flag, 1'h0, "flag cleared");
    sup(1500, 3000);
    sup(0, 0);
    chk(total_power_loss_flag, 1'h1, "flag on loss");
    sup(3300, 3000);
    chk(backup_mode, 1'h0, "repowered");
    chk(enables.serial_en, 1'h1, "normal after loss");
    @(posedge clk);
    alarm_event_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk(irq_oe, 1'h1, "no alarm");
    @(posedge clk);
    {alarm_event_n, fout_sel_en} <= 2'h1;
    repeat (3) @(posedge clk);
    #1;
    chk(fout_oe, 1'h0, "fout low");
    chk(irq_oe, 1'h1, "irq off");
    @(posedge clk);
    fout_clk <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk(fout_oe, 1'h1, "fout high");
    chk(fout_o, 1'h0, "fout level");
    @(posedge clk);
    {fout_clk, backup_fout_en} <= 2'h0;
    sup(1500, 3000);
    chk(fout_oe, 1'h1, "fout masked in backup");
    @(posedge clk);
    backup_fout_en <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk(fout_oe, 1'h0, "fout kept in backup");
    $display("test loss and outputs done");
  endtask

  // Main sequence
  initial begin
    {rstn, low_power_switch_mode_wr, low_power_switch_mode_in} = 3'h0;
    {total_power_loss_flag_clr, fout_clk, fout_sel_en, scl_in} = 4'h0;
    {backup_irq_en, backup_fout_en, sda_drive_low} = 3'h7;
    {alarm_event_n, sda_in} = 2'h0;
    main_mv = 0;
    bak_mv = 3000;
    num_errors = 0;
    compares = 0;
    t_reset();
    t_enter();
    t_lowpower();
    t_loss();
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
